// >>> dv/display_dram_write_refresh_sequencer_tb.sv
// Self-checking testbench for the display DRAM write and refresh sequencer.
module display_dram_write_refresh_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [1:0] len;
    logic       lead;
    logic [1:0] beats;
    logic [8:0] col;
    int         ras;
    int         cas;
    int         we;
  } case_s;

  logic                      i_clk, i_srst, i_ce, req_valid, req_ready;
  dram_seq_pkg::seq_cfg_s    cfg;
  dram_seq_pkg::seq_req_s    req;
  dram_seq_pkg::mem_pins_s   mem_pins;
  int                        n_mismatch = 0;
  int                        checks = 0;
  dram_seq_pkg::mem_pins_s   frozen;
  int                        exp_pulses[4] = '{1, 3, 5, 5};
  case_s                     rows[6] = '{
    '{2'h0, 1'b0, 2'h0, 9'h010, 7, 5, 1},
    '{2'h1, 1'b1, 2'h0, 9'h020, 8, 6, 4},
    '{2'h2, 1'b0, 2'h0, 9'h030, 9, 5, 1},
    '{2'h3, 1'b1, 2'h0, 9'h040, 10, 6, 4},
    '{2'h0, 1'b1, 2'h3, 9'h050, 19, 5, 4},
    '{2'h3, 1'b0, 2'h1, 9'h1FE, 14, 6, 1}};

  display_dram_write_refresh_sequencer dut (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_ce        (i_ce),
    .i_cfg       (cfg),
    .i_req_valid (req_valid),
    .i_req       (req),
    .o_req_ready (req_ready),
    .o_mem       (mem_pins)
  );

  dram_model mdl (
    .i_clk (i_clk),
    .i_mem (mem_pins)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Issues one request from idle and returns once the sequencer is idle again.
  task automatic run(input logic rf, input logic [1:0] beats, input logic [1:0] len,
                     input logic lead, input logic [1:0] pulses, input logic [8:0] col);
    int k;
    k = 0;
    @(posedge i_clk);
    req_valid <= 1'b1;
    req <= '{rf, beats, 9'h0A5, col, {16'hC0DE, 7'h00, col}};
    cfg <= '{len, lead, pulses};
    @(posedge i_clk);
    req_valid <= 1'b0;
    do
    begin
      @(negedge i_clk);
      k++;
    end
    while ((req_ready !== 1'b1 || k < 3) && k < 400);
    chk("ready_return", req_ready, 1'b1);
    repeat (2) @(posedge i_clk);
  endtask

  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    print_verdict();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    i_srst = 1'b1;
    i_ce = 1'b1;
    req_valid = 1'b0;
    req = '0;
    cfg = '0;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (rows[i])
    begin
      run(1'b0, rows[i].beats, rows[i].len, rows[i].lead, 2'h0, rows[i].col);
      chk("ras_low", mdl.ras_low, rows[i].ras);
      chk("cas_dly", mdl.cas_dly, rows[i].cas);
      chk("we_lead", mdl.we_lead, rows[i].we);
      chk("we_hold_ok", mdl.we_hold >= 3, 1'b1);
      chk("n_cas", mdl.n_cas, rows[i].beats + 1);
      chk("cas_per", mdl.cas_per, (rows[i].beats == 0) ? 0 : 4);
      chk("row_addr", mdl.row_addr, 9'h0A5);
      chk("dq_oe_n", mdl.oe_at_cas, 1'b0);
      for (int k = 0; k <= rows[i].beats; k++)
        chk("mem", mdl.mem[9'(rows[i].col + k)], {16'hC0DE, 7'h00, rows[i].col});
      $display("write case %0d done", i);
    end
    for (int p = 0; p < 4; p++)
    begin
      run(1'b1, 2'h0, 2'h0, 1'b0, p[1:0], 9'h000);
      chk("ref_pulses", mdl.ref_pulses, exp_pulses[p]);
      chk("ref_lead", mdl.ref_lead, 3);
      chk("ref_ras_low", mdl.ras_low, 7);
      if (p != 0) chk("ref_ras_high", mdl.ras_high, 5);
      chk("ref_cas_hold", mdl.cas_hold, 5);
      chk("ref_gap_ok", mdl.ras_to_cas >= 10, 1'b1);
      $display("refresh case %0d done", p);
    end
    @(posedge i_clk);
    req_valid <= 1'b1;
    cfg <= '{2'h3, 1'b1, 2'h0};
    @(posedge i_clk);
    req_valid <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_ce <= 1'b0;
    @(negedge i_clk);
    frozen = mem_pins;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk("ce_freeze", {mem_pins.ras_n, mem_pins.cas_n}, {frozen.ras_n, frozen.cas_n});
    chk("ce_strobes_low", {mem_pins.ras_n, mem_pins.cas_n}, 2'h0);
    chk("ce_ready", req_ready, 1'b0);
    @(posedge i_clk);
    i_ce <= 1'b1;
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    @(negedge i_clk);
    chk("reset_pins", {mem_pins.ras_n, mem_pins.cas_n, mem_pins.we_n, mem_pins.dq_oe_n}, 4'hF);
    chk("reset_addr", mem_pins.addr, 9'h000);
    chk("reset_ready", req_ready, 1'b1);
    run(1'b0, 2'h0, 2'h1, 1'b0, 2'h0, 9'h077);
    chk("ras_low_after_reset", mdl.ras_low, 8);
    chk("mem_after_reset", mdl.mem[9'h077], {16'hC0DE, 7'h00, 9'h077});
    $display("reset case done");
    print_verdict();
  end
endmodule // display_dram_write_refresh_sequencer_tb

// >>> dv/dram_model.sv
// Behavioural model of the display DRAMs that watches the strobes and keeps written words.
`include "dram_seq_params.svh"

module dram_model (
  input wire logic                    i_clk,
  input wire dram_seq_pkg::mem_pins_s i_mem
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // Strobe edge timing, in i_clk cycles (half memory periods)
  // --------------------------------------------------------------------------
  logic [31:0]        t = 0;
  logic [31:0]        t_ras_f = 0, t_ras_r = 0, t_cas_f = 0, t_cas_r = 0, t_we_f = 0;
  logic [31:0]        ras_low, ras_high, cas_dly, cas_per, we_lead, we_hold;
  logic [31:0]        ref_lead, ref_pulses = 0, cas_hold, ras_to_cas, n_cas = 0;
  logic [`ADDR_W-1:0] row_addr;
  logic               oe_at_cas;
  logic               ras_q = 1'b1, cas_q = 1'b1, we_q = 1'b1;
  logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

  // The array only latches on a column fall inside an open row; a column fall
  // with the row strobe high starts a refresh and stores nothing.
  always @(posedge i_clk)
  begin
    t = t + 1;
    if (cas_q && !i_mem.cas_n)
    begin
      if (i_mem.ras_n)
      begin
        ref_pulses = 0;
        ras_to_cas = t - t_ras_r;
      end
      else
      begin
        if (n_cas == 0)
        begin
          cas_dly = t - t_ras_f;
          we_lead = t - t_we_f;
        end
        else
          cas_per = t - t_cas_f;
        n_cas = n_cas + 1;
        oe_at_cas = i_mem.dq_oe_n;
        // An undriven data bus reads back inverted, so a missing drive window shows up.
        if (!i_mem.we_n) mem[i_mem.addr] = i_mem.dq_oe_n ? ~i_mem.dq_o : i_mem.dq_o;
      end
      t_cas_f = t;
    end
    if (ras_q && !i_mem.ras_n)
    begin
      ras_high = t - t_ras_r;
      t_ras_f = t;
      row_addr = i_mem.addr;
      if (i_mem.cas_n)
      begin
        n_cas = 0;
        cas_per = 0;
      end
      else
      begin
        if (ref_pulses == 0) ref_lead = t - t_cas_f;
        ref_pulses = ref_pulses + 1;
      end
    end
    if (!ras_q && i_mem.ras_n)
    begin
      ras_low = t - t_ras_f;
      t_ras_r = t;
    end
    if (!cas_q && i_mem.cas_n) cas_hold = t - t_ras_f;
    if (we_q && !i_mem.we_n) t_we_f = t;
    if (!we_q && i_mem.we_n) we_hold = t - t_cas_f;
    ras_q = i_mem.ras_n;
    cas_q = i_mem.cas_n;
    we_q = i_mem.we_n;
  end
endmodule // dram_model

// >>> hw/display_dram_write_refresh_sequencer.sv
// Write and column-before-row refresh strobe sequencer for the display DRAMs.
`include "dram_seq_params.svh"

// Contract
// - Write cycle lasts 6, 7, 8 or 9 periods, 2 more per extra beat: row-low phase plus precharge.
// - Row strobe low 3.5, 4.0, 4.5 or 5.0 periods per cycle length, plus 2 periods per extra beat.
// - Column strobe falls 2.5 periods after row fall (6/8), else 3.0.
// - Column accesses repeat every 2 periods, one low and one high.
// - Row address set one period before row fall, held 1.5 after.
// - Column address set one period before column fall, held one after.
// - Write strobe leads column fall by 2.0 periods if lead select, else 0.5.
// - Write strobe stays low at least 1.5 periods after column fall.
// - Write data driven one period before column fall, one period after.
// - Refresh lowers column strobe 1.5 periods before first row fall.
// - One, three or five row pulses, 3.5 low and 2.5 high each.
// - Column strobe stays low 2.5 periods after the last row fall.
// - Refreshes spaced by 10 half periods of recovery, next column fall at least 5.5 periods after row rise.
module display_dram_write_refresh_sequencer (
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  input  wire dram_seq_pkg::seq_cfg_s  i_cfg,
  input  wire logic                    i_req_valid,
  input  wire dram_seq_pkg::seq_req_s  i_req,
  output logic                         o_req_ready,
  output dram_seq_pkg::mem_pins_s      o_mem
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dram_seq_pkg::seq_state_e state_ff;
  dram_seq_pkg::seq_state_e nxt_state;
  dram_seq_pkg::seq_cfg_s   cfg_ff;
  dram_seq_pkg::seq_req_s   req_ff;
  dram_seq_pkg::mem_pins_s  nxt_mem;
  logic [`CNT_W-1:0]        h_ff;
  logic [`CNT_W-1:0]        nxt_h;
  logic [`CNT_W-1:0]        ph_ff;
  logic [`CNT_W-1:0]        ras_low_h;
  logic [`CNT_W-1:0]        ras_pre_h;
  logic [`CNT_W-1:0]        cas_dly_h;
  logic [`CNT_W-1:0]        we_lead_h;
  logic [`CNT_W-1:0]        last_fall_h;
  logic [`CNT_W-1:0]        ras_rise_h;
  logic [`CNT_W-1:0]        ref_span_h;
  logic [`CNT_W-1:0]        ref_end_h;
  logic [`CNT_W-1:0]        cas_rel_h;
  logic [`CNT_W-1:0]        col_step;
  logic                     accept;

  assign o_req_ready = (state_ff == dram_seq_pkg::ST_IDLE);
  assign accept      = i_req_valid && o_req_ready;

  // --------------------------------------------------------------------------
  // Timing derived from the latched configuration
  // --------------------------------------------------------------------------
  always_comb
  begin
    unique case (cfg_ff.cycle_length_setting)
      `CYC_6T:
      begin
        ras_low_h = `RAS_LOW_6T_H;
        ras_pre_h = `RAS_PRE_6T_H;
      end
      `CYC_7T:
      begin
        ras_low_h = `RAS_LOW_7T_H;
        ras_pre_h = `RAS_PRE_7T_H;
      end
      `CYC_8T:
      begin
        ras_low_h = `RAS_LOW_8T_H;
        ras_pre_h = `RAS_PRE_8T_H;
      end
      `CYC_9T:
      begin
        ras_low_h = `RAS_LOW_9T_H;
        ras_pre_h = `RAS_PRE_9T_H;
      end
    endcase
    // Odd cycle lengths use the longer delay.
    cas_dly_h = cfg_ff.cycle_length_setting[0] ? `CAS_DLY_ODD_H : `CAS_DLY_EVEN_H;
    we_lead_h = cfg_ff.write_strobe_lead_select ? `WE_LEAD_LONG_H : `WE_LEAD_SHORT_H;
    last_fall_h = cas_dly_h + {5'h00, req_ff.beats} * `CAS_CYCLE_H;
    // Burst accesses stretch the row-low phase by the extra column slots.
    ras_rise_h  = last_fall_h + ras_low_h - cas_dly_h;
    unique case (cfg_ff.refresh_pulses)
      `PULSES_1: ref_span_h = `REF_SPAN_1_H;
      `PULSES_3: ref_span_h = `REF_SPAN_3_H;
      default:   ref_span_h = `REF_SPAN_5_H;
    endcase
    ref_end_h = `REF_CAS_LEAD_H + ref_span_h + `REF_RAS_LOW_H;
    cas_rel_h = h_ff - cas_dly_h;
    col_step  = (h_ff + `COL_SETUP_H < cas_dly_h) ? '0
              : ((h_ff + `COL_SETUP_H - cas_dly_h) / `CAS_CYCLE_H);
  end

  // --------------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_h     = h_ff + 7'h01;
    unique case (state_ff)
      dram_seq_pkg::ST_IDLE:
      begin
        nxt_h = '0;
        if (accept)
        begin
          nxt_state = i_req.is_refresh ? dram_seq_pkg::ST_REF_ACT : dram_seq_pkg::ST_ROW_SETUP;
        end
      end
      dram_seq_pkg::ST_ROW_SETUP:
      begin
        if (h_ff == `ROW_SETUP_H - 7'h01)
        begin
          nxt_state = dram_seq_pkg::ST_WRITE_ACT;
          nxt_h     = '0;
        end
      end
      dram_seq_pkg::ST_WRITE_ACT:
      begin
        if (h_ff == ras_rise_h - 7'h01)
        begin
          nxt_state = dram_seq_pkg::ST_WRITE_PRE;
          nxt_h     = '0;
        end
      end
      dram_seq_pkg::ST_WRITE_PRE:
      begin
        if (h_ff == ras_pre_h - 7'h01)
        begin
          nxt_state = dram_seq_pkg::ST_IDLE;
          nxt_h     = '0;
        end
      end
      dram_seq_pkg::ST_REF_ACT:
      begin
        if (h_ff == ref_end_h - 7'h01)
        begin
          nxt_state = dram_seq_pkg::ST_REF_REC;
          nxt_h     = '0;
        end
      end
      dram_seq_pkg::ST_REF_REC:
      begin
        if (h_ff == `REF_RECOVER_H - 7'h01)
        begin
          nxt_state = dram_seq_pkg::ST_IDLE;
          nxt_h     = '0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_ff <= dram_seq_pkg::ST_IDLE;
      h_ff     <= '0;
    end
    else if (i_ce)
    begin
      state_ff <= nxt_state;
      h_ff     <= nxt_h;
    end
  end

  // Phase inside one refresh row pulse; a counter avoids a modulo-12 divider.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ph_ff <= '0;
    end
    else if (i_ce)
    begin
      if (state_ff != dram_seq_pkg::ST_REF_ACT || h_ff + 7'h01 < `REF_CAS_LEAD_H)
      begin
        ph_ff <= '0;
      end
      else if (h_ff + 7'h01 == `REF_CAS_LEAD_H || ph_ff == `REF_PULSE_H - 7'h01)
      begin
        ph_ff <= '0;
      end
      else
      begin
        ph_ff <= ph_ff + 7'h01;
      end
    end
  end

  // Settings are held for the whole request so a change mid-cycle cannot tear it.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cfg_ff <= '0;
      req_ff <= '0;
    end
    else if (i_ce && accept)
    begin
      cfg_ff <= i_cfg;
      req_ff <= i_req;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_mem         = '0;
    nxt_mem.ras_n   = 1'b1;
    nxt_mem.cas_n   = 1'b1;
    nxt_mem.we_n    = 1'b1;
    nxt_mem.dq_oe_n = `OE_OFF;
    nxt_mem.addr    = req_ff.row;
    nxt_mem.dq_o    = req_ff.data;
    unique case (state_ff)
      dram_seq_pkg::ST_WRITE_ACT:
      begin
        nxt_mem.ras_n = 1'b0;
        if (h_ff >= `ROW_HOLD_H)
        begin
          nxt_mem.addr = req_ff.col + {{(`ADDR_W-`CNT_W){1'b0}}, col_step};
        end
        if (h_ff >= cas_dly_h && h_ff <= last_fall_h + 7'h01
            && (cas_rel_h & `CAS_PHASE_MASK) < `CAS_LOW_H)
        begin
          nxt_mem.cas_n = 1'b0;
        end
        if (h_ff + we_lead_h >= cas_dly_h && h_ff < last_fall_h + `WE_HOLD_H)
        begin
          nxt_mem.we_n = 1'b0;
        end
        if (h_ff + `COL_SETUP_H >= cas_dly_h && h_ff < last_fall_h + `CAS_LOW_H)
        begin
          nxt_mem.dq_oe_n = `OE_ON;
        end
      end
      dram_seq_pkg::ST_WRITE_PRE:
      begin
        // A short row-low phase ends before the write hold does, so the hold runs into precharge.
        if (ras_rise_h + h_ff < last_fall_h + `WE_HOLD_H)
        begin
          nxt_mem.we_n = 1'b0;
        end
      end
      dram_seq_pkg::ST_REF_ACT:
      begin
        nxt_mem.cas_n = !(h_ff < `REF_CAS_LEAD_H + ref_span_h + `REF_CAS_HOLD_H);
        nxt_mem.ras_n = !(h_ff >= `REF_CAS_LEAD_H && ph_ff < `REF_RAS_LOW_H);
      end
      default:
      begin
        nxt_mem.ras_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_mem         <= '0;
      o_mem.ras_n   <= 1'b1;
      o_mem.cas_n   <= 1'b1;
      o_mem.we_n    <= 1'b1;
      o_mem.dq_oe_n <= `OE_OFF;
    end
    else if (i_ce)
    begin
      o_mem <= nxt_mem;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst || !i_ce);

  write_ras_low_a: assert property (
    $fell(o_mem.ras_n) && !req_ff.is_refresh && cfg_ff.cycle_length_setting == `CYC_6T
      && req_ff.beats == 2'h0 |-> !o_mem.ras_n [*7] ##1 o_mem.ras_n)
    else $error("Write row strobe low time wrong.");

  write_precharge_a: assert property (
    $rose(o_mem.ras_n) && !req_ff.is_refresh && cfg_ff.cycle_length_setting == `CYC_9T
      |-> o_mem.ras_n [*8])
    else $error("Write precharge too short.");

  cas_delay_a: assert property (
    $fell(o_mem.ras_n) && !req_ff.is_refresh && !cfg_ff.cycle_length_setting[0]
      |-> o_mem.cas_n [*5] ##1 !o_mem.cas_n)
    else $error("Row to column strobe delay wrong.");

  cas_cycle_a: assert property (
    $fell(o_mem.cas_n) && !req_ff.is_refresh |-> !o_mem.cas_n ##1 !o_mem.cas_n ##1 o_mem.cas_n)
    else $error("Column strobe low width wrong.");

  row_addr_hold_a: assert property (
    $fell(o_mem.ras_n) && !req_ff.is_refresh |-> $stable(o_mem.addr) [*3])
    else $error("Row address not held.");

  we_lead_a: assert property (
    $fell(o_mem.cas_n) && !req_ff.is_refresh && cfg_ff.write_strobe_lead_select
      |-> $past(!o_mem.we_n, 4) && o_mem.we_n == 1'b0)
    else $error("Write strobe lead wrong.");

  we_hold_a: assert property (
    $fell(o_mem.cas_n) && !req_ff.is_refresh |-> !o_mem.we_n [*3])
    else $error("Write strobe released early.");

  data_window_a: assert property (
    $fell(o_mem.cas_n) && !req_ff.is_refresh
      |-> $past(o_mem.dq_oe_n == `OE_ON, 2) && (o_mem.dq_oe_n == `OE_ON) [*2])
    else $error("Write data window wrong.");

  ref_order_a: assert property (
    $fell(o_mem.cas_n) && req_ff.is_refresh |-> o_mem.ras_n [*3] ##1 !o_mem.ras_n)
    else $error("Refresh column lead wrong.");

  ref_pulse_a: assert property (
    $fell(o_mem.ras_n) && req_ff.is_refresh |-> !o_mem.ras_n [*7] ##1 o_mem.ras_n [*5])
    else $error("Refresh row pulse shape wrong.");

endmodule // display_dram_write_refresh_sequencer

// >>> hw/dram_seq_params.svh
// Timing counts, encodings and widths for the display DRAM write and refresh sequencer.
`ifndef DRAM_SEQ_PARAMS_SVH
`define DRAM_SEQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define ADDR_W 9
`define DATA_W 32
`define CNT_W  7

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define CYC_6T      2'h0
`define CYC_7T      2'h1
`define CYC_8T      2'h2
`define CYC_9T      2'h3
`define PULSES_1    2'h0
`define PULSES_3    2'h1
`define OE_ON       1'b0
`define OE_OFF      1'b1

// ----------------------------------------------------------------------------
// Counts in half memory-clock periods (one i_clk cycle each)
// ----------------------------------------------------------------------------
`define ROW_SETUP_H     7'h02
`define COL_SETUP_H     7'h02
`define ROW_HOLD_H      7'h03
`define CAS_CYCLE_H     7'h04
`define CAS_LOW_H       7'h02
`define CAS_PHASE_MASK  7'h03
`define CAS_DLY_EVEN_H  7'h05
`define CAS_DLY_ODD_H   7'h06
`define WE_LEAD_LONG_H  7'h04
`define WE_LEAD_SHORT_H 7'h01
`define WE_HOLD_H       7'h03
`define RAS_LOW_6T_H    7'h07
`define RAS_LOW_7T_H    7'h08
`define RAS_LOW_8T_H    7'h09
`define RAS_LOW_9T_H    7'h0A
`define RAS_PRE_6T_H    7'h05
`define RAS_PRE_7T_H    7'h06
`define RAS_PRE_8T_H    7'h07
`define RAS_PRE_9T_H    7'h08
`define REF_CAS_LEAD_H  7'h03
`define REF_RAS_LOW_H   7'h07
`define REF_PULSE_H     7'h0C
`define REF_CAS_HOLD_H  7'h05
`define REF_RECOVER_H   7'h0A
`define REF_SPAN_1_H    7'h00
`define REF_SPAN_3_H    7'h18
`define REF_SPAN_5_H    7'h30

`endif

// >>> hw/dram_seq_pkg.sv
// Types shared by the display DRAM sequencer and its users.
`include "dram_seq_params.svh"

package dram_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW_SETUP,
    ST_WRITE_ACT,
    ST_WRITE_PRE,
    ST_REF_ACT,
    ST_REF_REC
  } seq_state_e;

  typedef struct packed {
    logic [1:0] cycle_length_setting;
    logic       write_strobe_lead_select;
    logic [1:0] refresh_pulses;
  } seq_cfg_s;

  typedef struct packed {
    logic                 is_refresh;
    logic [1:0]           beats;
    logic [`ADDR_W-1:0]   row;
    logic [`ADDR_W-1:0]   col;
    logic [`DATA_W-1:0]   data;
  } seq_req_s;

  typedef struct packed {
    logic                 ras_n;
    logic                 cas_n;
    logic                 we_n;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   dq_o;
    logic                 dq_oe_n;
  } mem_pins_s;

endpackage
